// >>> src/flash_read_host.sv
// Implementation choices: the register offsets and register access over AHB-Lite.
module flash_read_host #(
  parameter int SCLK_HALF = flash_read_pkg::SCLK_HALF_CYC
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  flash_link_if.host link
);
  import flash_read_pkg::*;

  typedef enum logic [6:0] {
    P_IDLE = 7'b0000001,
    P_OPC = 7'b0000010,
    P_ADDR = 7'b0000100,
    P_MODE = 7'b0001000,
    P_DUMMY = 7'b0010000,
    P_DATA = 7'b0100000,
    P_GAP = 7'b1000000
  } host_phase_t;

  localparam logic [7:0] HALF_L = 8'(SCLK_HALF);
  localparam logic [7:0] LAST_L = 8'(2 * SCLK_HALF - 1);

  host_phase_t ph_reg, after_ph;
  cmd_cfg_t cfg_reg, dec;
  logic [7:0] cmd_op_reg, mode_reg, div_reg, div_nx, rx_sh_reg, rx_new;
  logic [7:0] rx_data_reg, wr_addr_reg;
  logic [23:0] addr_reg;
  logic [15:0] count_reg, bytes_left_reg;
  logic [4:0] clk_left_reg, after_clk;
  logic [39:0] tx_reg;
  logic [2:0] rx_pos_reg, tx_lanes;
  logic [3:0] io_meta_reg, io_sync_reg;
  logic rx_valid_reg, wr_pend_reg, cs_b_reg, sclk_reg;
  logic addr_ok, start, rd_data_hit, stall, tick, byte_done, drive;
  logic [31:0] rd_mux;

  assign addr_ok = hsel & htrans[1] & hready;
  assign rd_data_hit = addr_ok & ~hwrite & (haddr[7:0] == REG_DATA);
  assign start = wr_pend_reg & (wr_addr_reg == REG_CMD) & (ph_reg == P_IDLE);
  assign dec = cmd_decode(hwdata[7:0]);

  always_comb begin
    case (haddr[7:0])
      REG_CMD: rd_mux = {24'h0, cmd_op_reg};
      REG_ADDR: rd_mux = {8'h0, addr_reg};
      REG_MODE: rd_mux = {24'h0, mode_reg};
      REG_COUNT: rd_mux = {16'h0, count_reg};
      REG_DATA: rd_mux = {23'h0, rx_valid_reg, rx_data_reg};
      REG_STATUS: rd_mux = {30'h0, ph_reg != P_IDLE, rx_valid_reg};
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h0;
      hrdata <= 32'h0;
    end else begin
      wr_pend_reg <= addr_ok & hwrite;
      if (addr_ok) begin
        wr_addr_reg <= haddr[7:0];
      end
      if (addr_ok & ~hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      addr_reg <= 24'h0;
      mode_reg <= 8'h0;
      count_reg <= 16'h0;
    end else if (wr_pend_reg) begin
      case (wr_addr_reg)
        REG_ADDR: addr_reg <= hwdata[23:0];
        REG_MODE: mode_reg <= hwdata[7:0];
        REG_COUNT: count_reg <= hwdata[15:0];
        default: addr_reg <= addr_reg;
      endcase
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      io_meta_reg <= 4'hf;
      io_sync_reg <= 4'hf;
    end else begin
      io_meta_reg <= link.io_level;
      io_sync_reg <= io_meta_reg;
    end
  end

  // Without a buffer the clock pauses at a byte boundary until read
  assign stall = (ph_reg == P_DATA) & (rx_pos_reg == 3'h0) & rx_valid_reg &
                 (div_reg == 8'h0);
  // Sample late in the high half to cover device and sync delay
  assign tick = (ph_reg != P_IDLE) & ~stall & (div_reg == LAST_L);
  assign div_nx = (div_reg == LAST_L) ? 8'h0 : 8'(div_reg + 8'h1);
  assign tx_lanes = (ph_reg == P_OPC) ? 3'd1 : cfg_reg.in_lanes;
  assign drive = (ph_reg == P_OPC) | (ph_reg == P_ADDR) | (ph_reg == P_MODE);

  always_comb begin
    case (cfg_reg.out_lanes)
      3'd4: rx_new = {rx_sh_reg[3:0], io_sync_reg};
      3'd2: rx_new = {rx_sh_reg[5:0], io_sync_reg[1:0]};
      default: rx_new = {rx_sh_reg[6:0], io_sync_reg[1]};
    endcase
  end

  always_comb begin
    if (cfg_reg.wrap_cfg || bytes_left_reg == 16'h0) begin
      after_ph = P_GAP;
      after_clk = 5'h0;
    end else if (cfg_reg.dummy != 4'h0) begin
      after_ph = P_DUMMY;
      after_clk = 5'({1'b0, cfg_reg.dummy} - 5'd1);
    end else begin
      after_ph = P_DATA;
      after_clk = 5'h0;
    end
  end

  assign byte_done = tick & (ph_reg == P_DATA) &
    (({1'b0, rx_pos_reg} + {1'b0, cfg_reg.out_lanes}) == 4'h8);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ph_reg <= P_IDLE;
      cfg_reg <= '0;
      cmd_op_reg <= 8'h0;
      tx_reg <= 40'h0;
      clk_left_reg <= 5'h0;
      bytes_left_reg <= 16'h0;
      div_reg <= 8'h0;
      sclk_reg <= 1'b0;
      cs_b_reg <= 1'b1;
    end else if (start) begin
      cfg_reg <= dec;
      cmd_op_reg <= hwdata[7:0];
      bytes_left_reg <= count_reg;
      div_reg <= 8'h0;
      cs_b_reg <= 1'b0;
      if (hwdata[7:0] == OP_MODE_RESET) begin
        ph_reg <= P_OPC;
        tx_reg <= {40{1'b1}};
        clk_left_reg <= 5'((hwdata[9] ? RESET_CLKS_DUAL : RESET_CLKS_QUAD)
                           - 5'd1);
      end else if (hwdata[8]) begin
        ph_reg <= P_ADDR;
        tx_reg <= {addr_reg[23:1], addr_reg[0] & (hwdata[7:0] !=
                   OP_WORD_QUAD_IO), mode_reg, 8'h0};
        clk_left_reg <= 5'(addr_clks(dec.in_lanes) - 5'd1);
      end else begin
        ph_reg <= P_OPC;
        tx_reg <= {hwdata[7:0], dec.wrap_cfg ? 24'h0 : {addr_reg[23:1],
                   addr_reg[0] & (hwdata[7:0] != OP_WORD_QUAD_IO)},
                   mode_reg};
        clk_left_reg <= 5'(OPCODE_CLKS - 5'd1);
      end
    end else if (ph_reg != P_IDLE && !stall) begin
      div_reg <= div_nx;
      sclk_reg <= (ph_reg != P_GAP) && (div_nx >= HALF_L);
      if (tick) begin
        clk_left_reg <= 5'(clk_left_reg - 5'd1);
        case (tx_lanes)
          3'd4: tx_reg <= {tx_reg[35:0], 4'h0};
          3'd2: tx_reg <= {tx_reg[37:0], 2'h0};
          default: tx_reg <= {tx_reg[38:0], 1'b0};
        endcase
        case (ph_reg)
          P_OPC: begin
            if (clk_left_reg == 5'h0) begin
              if (cmd_op_reg == OP_MODE_RESET || !cfg_reg.valid) begin
                ph_reg <= P_GAP;
              end else begin
                ph_reg <= P_ADDR;
                clk_left_reg <= 5'(addr_clks(cfg_reg.in_lanes) - 5'd1);
              end
            end
          end
          P_ADDR: begin
            if (clk_left_reg == 5'h0) begin
              ph_reg <= cfg_reg.has_mode ? P_MODE : after_ph;
              clk_left_reg <= cfg_reg.has_mode ?
                5'(mode_clks(cfg_reg.in_lanes) - 5'd1) : after_clk;
            end
          end
          P_MODE, P_DUMMY: begin
            if (clk_left_reg == 5'h0) begin
              ph_reg <= (ph_reg == P_MODE) ? after_ph : P_DATA;
              clk_left_reg <= after_clk;
            end
          end
          P_DATA: begin
            if (byte_done) begin
              bytes_left_reg <= 16'(bytes_left_reg - 16'h1);
              if (bytes_left_reg == 16'h1) begin
                ph_reg <= P_GAP;
              end
            end
          end
          P_GAP: ph_reg <= P_IDLE;
          default: ph_reg <= P_IDLE;
        endcase
        if (ph_reg != P_GAP && (after_ph == P_GAP || ph_reg == P_DATA)) begin
          cs_b_reg <= cs_b_reg;
        end
      end
    end
  end

  // Chip select rises with the end of the last clock and stays up one period
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rx_sh_reg <= 8'h0;
      rx_pos_reg <= 3'h0;
      rx_data_reg <= 8'h0;
      rx_valid_reg <= 1'b0;
    end else begin
      if (start) begin
        rx_pos_reg <= 3'h0;
      end else if (tick && ph_reg == P_DATA) begin
        rx_sh_reg <= rx_new;
        rx_pos_reg <= 3'(rx_pos_reg + cfg_reg.out_lanes);
      end
      if (byte_done) begin
        rx_data_reg <= rx_new;
        rx_valid_reg <= 1'b1;
      end else if (rd_data_hit) begin
        rx_valid_reg <= 1'b0;
      end
    end
  end

  assign link.sclk = sclk_reg;
  assign link.cs_b = cs_b_reg | (ph_reg == P_GAP) | (ph_reg == P_IDLE);
  assign link.host_io_out = (tx_lanes == 3'd4) ? tx_reg[39:36] :
                            (tx_lanes == 3'd2) ? {2'b00, tx_reg[39:38]} :
                            {3'b000, tx_reg[39]};
  // Lines drop at the last address, mode or opcode clock, before data
  assign link.host_io_oe = !drive ? 4'h0 :
                           (tx_lanes == 3'd4) ? 4'hf :
                           (tx_lanes == 3'd2) ? 4'h3 : 4'h1;
endmodule : flash_read_host

// >>> src/flash_read_pkg.sv
package flash_read_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int SCLK_PERIOD_NS = 800;
  localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int MEM_AW_DEFAULT = 10;
  localparam logic [7:0] OP_FAST_READ = 8'h0b;
  localparam logic [7:0] OP_DUAL_OUT = 8'h3b;
  localparam logic [7:0] OP_QUAD_OUT = 8'h6b;
  localparam logic [7:0] OP_DUAL_IO = 8'hbb;
  localparam logic [7:0] OP_QUAD_IO = 8'heb;
  localparam logic [7:0] OP_WORD_QUAD_IO = 8'he7;
  localparam logic [7:0] OP_SET_WRAP = 8'h77;
  localparam logic [7:0] OP_MODE_RESET = 8'hff;
  localparam logic [1:0] OPCODE_SKIP_CODE = 2'b10;
  localparam logic [2:0] WRAP_SETTING_RESET = 3'b001;
  localparam logic [7:0] MODE_BYTE_RESET = 8'h00;
  localparam logic [3:0] DUMMY_SINGLE = 4'h8;
  localparam logic [3:0] DUMMY_QUAD_IO = 4'h4;
  localparam logic [3:0] DUMMY_WORD_IO = 4'h2;
  localparam logic [4:0] OPCODE_CLKS = 5'h08;
  localparam logic [4:0] RESET_CLKS_QUAD = 5'h08;
  localparam logic [4:0] RESET_CLKS_DUAL = 5'h10;
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_MODE = 8'h08;
  localparam logic [7:0] REG_COUNT = 8'h0c;
  localparam logic [7:0] REG_DATA = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;

  typedef struct packed {
    logic valid;
    logic [2:0] in_lanes;
    logic [2:0] out_lanes;
    logic [3:0] dummy;
    logic has_mode;
    logic wrap_ok;
    logic needs_quad;
    logic wrap_cfg;
  } cmd_cfg_t;

  function automatic cmd_cfg_t cmd_decode(input logic [7:0] op);
    cmd_cfg_t c;
    c = '0;
    case (op)
      OP_FAST_READ: c = '{1'b1, 3'd1, 3'd1, DUMMY_SINGLE, 1'b0, 1'b0, 1'b0, 1'b0};
      OP_DUAL_OUT: c = '{1'b1, 3'd1, 3'd2, DUMMY_SINGLE, 1'b0, 1'b0, 1'b0, 1'b0};
      OP_QUAD_OUT: c = '{1'b1, 3'd1, 3'd4, DUMMY_SINGLE, 1'b0, 1'b0, 1'b1, 1'b0};
      OP_DUAL_IO: c = '{1'b1, 3'd2, 3'd2, 4'h0, 1'b1, 1'b0, 1'b0, 1'b0};
      OP_QUAD_IO: c = '{1'b1, 3'd4, 3'd4, DUMMY_QUAD_IO, 1'b1, 1'b1, 1'b1, 1'b0};
      OP_WORD_QUAD_IO: c = '{1'b1, 3'd4, 3'd4, DUMMY_WORD_IO, 1'b1, 1'b1, 1'b1, 1'b0};
      OP_SET_WRAP: c = '{1'b1, 3'd4, 3'd4, 4'h0, 1'b1, 1'b0, 1'b0, 1'b1};
      default: c = '0;
    endcase
    return c;
  endfunction : cmd_decode

  function automatic logic [4:0] addr_clks(input logic [2:0] lanes);
    case (lanes)
      3'd4: return 5'd6;
      3'd2: return 5'd12;
      default: return 5'd24;
    endcase
  endfunction : addr_clks

  function automatic logic [4:0] mode_clks(input logic [2:0] lanes);
    case (lanes)
      3'd4: return 5'd2;
      3'd2: return 5'd4;
      default: return 5'd8;
    endcase
  endfunction : mode_clks
endpackage : flash_read_pkg

// >>> src/flash_link_if.sv
interface flash_link_if;
  logic sclk;
  logic cs_b;
  logic [3:0] host_io_out;
  logic [3:0] host_io_oe;
  logic [3:0] dev_io_out;
  logic [3:0] dev_io_oe;
  logic [3:0] io_level;

  // Undriven lines float high, as with the board pull-ups
  for (genvar i = 0; i < 4; i++) begin : g_line
    assign io_level[i] = host_io_oe[i] ? host_io_out[i] :
                         dev_io_oe[i] ? dev_io_out[i] : 1'b1;
  end

  modport host (output sclk, output cs_b, output host_io_out,
                output host_io_oe, input io_level);
  modport dev (input sclk, input cs_b, input io_level,
               output dev_io_out, output dev_io_oe);
endinterface : flash_link_if

// >>> src/flash_read_device.sv
// Overview of operation
// - Fast read: opcode, 24-bit address, eight dummies
// - Output lines meaningless during dummy clocks
// - Dual output read returns data on two lines
// - Host releases IO0 before first data fall
// - Quad output read needs quad enable bit
// - Host releases shared lines before data out
// - Dual I/O sends address over two lines
// - Mode byte follows address; bits 5:4 decide
// - Mode bits 10 make next frame skip opcode
// - Other mode bits restore opcode-first frames
// - Mode reset command ends opcode skipping
// - Quad I/O read: four lines, four dummies
// - Quad I/O read rejected without quad enable
// - Wrap restarts inside 8-64 byte page section
// - Wrap setting: disable bit plus length select
// - Word quad read: even address, two dummies
// - Word quad read needs quad enable, skips opcode only after mode bits 10
// - Mode reset: 8 ones quad, 16 dual
// - Wrap command: opcode, 24 dummies, wrap byte
// - Wrap disabled after reset; codes pick length
// - Address advances after each output byte
module flash_read_device #(
  parameter int MEM_AW = flash_read_pkg::MEM_AW_DEFAULT
) (
  input wire logic clock,
  input wire logic rst_b,
  flash_link_if.dev link,
  input wire logic quad_lines_enable_bit,
  input wire logic load_en,
  input wire logic [MEM_AW-1:0] load_addr,
  input wire logic [7:0] load_data,
  output logic [7:0] continuous_read_mode_byte,
  output logic opcode_skip_active,
  output logic [2:0] wrap_setting_bits,
  output logic frame_active
);
  import flash_read_pkg::*;

  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001,
    ST_OPCODE = 7'b0000010,
    ST_ADDR = 7'b0000100,
    ST_MODE = 7'b0001000,
    ST_DUMMY = 7'b0010000,
    ST_DATA = 7'b0100000,
    ST_IGNORE = 7'b1000000
  } dev_state_t;

  logic [7:0] mem [0:(1<<MEM_AW)-1];
  logic [5:0] in_meta_reg, in_sync_reg;
  logic sclk_prev_reg, cs_prev_reg;
  dev_state_t state_reg, after_addr, after_mode;
  cmd_cfg_t cfg_reg, dec;
  logic [4:0] cnt_reg, phase_len;
  logic [31:0] sh_reg, sh_next;
  logic [23:0] addr_reg, addr_inc, addr_next;
  logic [7:0] byte_reg, src, shifted, wmask;
  logic [2:0] pos_reg, lanes;
  logic [7:0] mode_reg;
  logic skip_reg;
  logic [2:0] wrap_reg;
  logic [3:0] dout_reg, doe_reg;
  logic sclk_s, cs_s, rise, fall, cs_fall, last, accept, wrap_on;
  logic [3:0] io_s;

  // Pins cross from the link domain through two flops each
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      in_meta_reg <= 6'h1f;
      in_sync_reg <= 6'h1f;
      sclk_prev_reg <= 1'b0;
      cs_prev_reg <= 1'b1;
    end else begin
      in_meta_reg <= {link.sclk, link.cs_b, link.io_level};
      in_sync_reg <= in_meta_reg;
      sclk_prev_reg <= sclk_s;
      cs_prev_reg <= cs_s;
    end
  end

  assign sclk_s = in_sync_reg[5];
  assign cs_s = in_sync_reg[4];
  assign io_s = in_sync_reg[3:0];
  assign rise = sclk_s & ~sclk_prev_reg & ~cs_s;
  assign fall = ~sclk_s & sclk_prev_reg & ~cs_s;
  assign cs_fall = ~cs_s & cs_prev_reg;

  assign lanes = (state_reg == ST_OPCODE) ? 3'd1 : cfg_reg.in_lanes;

  always_comb begin
    case (lanes)
      3'd4: sh_next = {sh_reg[27:0], io_s};
      3'd2: sh_next = {sh_reg[29:0], io_s[1:0]};
      default: sh_next = {sh_reg[30:0], io_s[0]};
    endcase
  end

  assign dec = cmd_decode(sh_next[7:0]);
  assign accept = dec.valid & ~(dec.needs_quad & ~quad_lines_enable_bit);

  always_comb begin
    case (state_reg)
      ST_OPCODE: phase_len = OPCODE_CLKS;
      ST_ADDR: phase_len = addr_clks(cfg_reg.in_lanes);
      ST_MODE: phase_len = mode_clks(cfg_reg.in_lanes);
      ST_DUMMY: phase_len = {1'b0, cfg_reg.dummy};
      default: phase_len = 5'h1f;
    endcase
  end

  assign last = (cnt_reg == 5'(phase_len - 5'd1));
  // Mode bytes close the gap in dual I/O; wrap command has no data
  assign after_mode = cfg_reg.wrap_cfg ? ST_IGNORE :
                      (cfg_reg.dummy != 4'h0) ? ST_DUMMY : ST_DATA;
  assign after_addr = cfg_reg.has_mode ? ST_MODE : after_mode;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 5'h00;
    end else if (cs_s) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 5'h00;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (cs_fall) begin
            state_reg <= skip_reg ? ST_ADDR : ST_OPCODE;
            cnt_reg <= 5'h00;
          end
        end
        ST_OPCODE, ST_ADDR, ST_MODE, ST_DUMMY: begin
          if (rise) begin
            cnt_reg <= last ? 5'h00 : 5'(cnt_reg + 5'd1);
            if (last) begin
              case (state_reg)
                ST_OPCODE: state_reg <= accept ? ST_ADDR : ST_IGNORE;
                ST_ADDR: state_reg <= after_addr;
                ST_MODE: state_reg <= after_mode;
                default: state_reg <= ST_DATA;
              endcase
            end
          end
        end
        ST_DATA, ST_IGNORE: state_reg <= state_reg;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cfg_reg <= '0;
    end else if (state_reg == ST_OPCODE && rise && last && accept) begin
      cfg_reg <= dec;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sh_reg <= 32'h0;
    end else if (cs_fall) begin
      sh_reg <= 32'h0;
    end else if (rise && (state_reg == ST_OPCODE || state_reg == ST_ADDR ||
                          state_reg == ST_MODE)) begin
      sh_reg <= sh_next;
    end
  end

  // Mode byte and wrap setting survive chip select going high
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mode_reg <= MODE_BYTE_RESET;
      skip_reg <= 1'b0;
      wrap_reg <= WRAP_SETTING_RESET;
    end else if (rise && last && state_reg == ST_MODE) begin
      if (cfg_reg.wrap_cfg) begin
        wrap_reg <= sh_next[6:4];
      end else begin
        mode_reg <= sh_next[7:0];
        skip_reg <= (sh_next[5:4] == OPCODE_SKIP_CODE);
      end
    end else if (rise && last && state_reg == ST_OPCODE &&
                 sh_next[7:0] == OP_MODE_RESET) begin
      skip_reg <= 1'b0;
    end
  end

  assign wrap_on = cfg_reg.wrap_ok & ~wrap_reg[0];
  assign wmask = 8'((8'h08 << wrap_reg[2:1]) - 8'h01);
  assign addr_inc = 24'(addr_reg + 24'h1);
  assign addr_next = wrap_on ?
    {addr_reg[23:8], (addr_reg[7:0] & ~wmask) | (addr_inc[7:0] & wmask)} :
    addr_inc;

  assign src = (pos_reg == 3'h0) ? mem[addr_reg[MEM_AW-1:0]] : byte_reg;
  assign shifted = 8'(src << pos_reg);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      addr_reg <= 24'h0;
    end else if (rise && last && state_reg == ST_ADDR) begin
      addr_reg <= sh_next[23:0];
    end else if (fall && state_reg == ST_DATA &&
                 ({1'b0, pos_reg} + {1'b0, cfg_reg.out_lanes}) == 4'h8) begin
      addr_reg <= addr_next;
    end
  end

  // Lines stay released outside data, so dummy clocks show nothing
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      dout_reg <= 4'h0;
      doe_reg <= 4'h0;
      pos_reg <= 3'h0;
      byte_reg <= 8'h0;
    end else if (state_reg != ST_DATA) begin
      doe_reg <= 4'h0;
      pos_reg <= 3'h0;
    end else if (fall) begin
      byte_reg <= src;
      pos_reg <= 3'(pos_reg + cfg_reg.out_lanes);
      case (cfg_reg.out_lanes)
        3'd4: begin
          dout_reg <= shifted[7:4];
          doe_reg <= 4'hf;
        end
        3'd2: begin
          dout_reg <= {2'b00, shifted[7:6]};
          doe_reg <= 4'h3;
        end
        default: begin
          dout_reg <= {2'b00, shifted[7], 1'b0};
          doe_reg <= 4'h2;
        end
      endcase
    end
  end

  // Backdoor load only; there is no erase or program path here
  always_ff @(posedge clock) begin
    if (load_en) begin
      mem[load_addr] <= load_data;
    end
  end

  assign link.dev_io_out = dout_reg;
  assign link.dev_io_oe = doe_reg;
  assign continuous_read_mode_byte = mode_reg;
  assign opcode_skip_active = skip_reg;
  assign wrap_setting_bits = wrap_reg;
  assign frame_active = (state_reg != ST_IDLE);
endmodule : flash_read_device

// >>> bench/flash_read_props.sv
module flash_read_props (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic sclk,
  input wire logic cs_b,
  input wire logic [3:0] host_io_out,
  input wire logic [3:0] host_io_oe,
  input wire logic [3:0] dev_io_out,
  input wire logic [3:0] dev_io_oe
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  // A late release shows up as both ends driving one line
  a_no_line_fight:
    assert property ((host_io_oe & dev_io_oe) == 4'h0)
    else $error("line fight");
  a_dev_lane_set:
    assert property (dev_io_oe inside {4'h0, 4'h2, 4'h3, 4'hf})
    else $error("bad lane set");
  a_sclk_high_half:
    assert property ($rose(sclk) |-> sclk [*4])
    else $error("short high half");
  a_sclk_low_half:
    assert property ($fell(sclk) |-> !sclk [*4])
    else $error("short low half");
  a_cs_high_gap:
    assert property ($rose(cs_b) |-> cs_b [*8])
    else $error("short deselect");
  a_sclk_idle_low:
    assert property (cs_b |-> !sclk)
    else $error("clock while idle");
  a_dev_quiet_idle:
    assert property (cs_b [*6] |-> dev_io_oe == 4'h0)
    else $error("device drives idle");
  a_dev_out_low:
    assert property ((|dev_io_oe) && $changed(dev_io_out) |-> !sclk)
    else $error("data moved on high");
  a_host_out_fall:
    assert property (!cs_b && (|host_io_oe) && $changed(host_io_out)
      |-> $fell(sclk) || $fell(cs_b))
    else $error("host moved off fall");
  c_frame: cover property ($rose(cs_b));
  c_one: cover property (dev_io_oe == 4'h2);
  c_two: cover property (dev_io_oe == 4'h3);
  c_four: cover property (dev_io_oe == 4'hf);
endmodule : flash_read_props

// >>> bench/serial_flash_multi_io_read_tb.sv
module serial_flash_multi_io_read_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import flash_read_pkg::*;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic qe = 1'b1;
  logic ld = 1'b0;
  logic [9:0] ld_a = 10'h0;
  logic [7:0] ld_d = 8'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic hready;
  logic hresp;
  logic [31:0] hrdata;
  logic [31:0] r;
  logic [7:0] mode_b;
  logic skip;
  logic fa;
  logic [2:0] wrap;
  logic [2:0] wrap_e;
  logic [7:0] mem [1024];
  logic [7:0] ops [6] = '{OP_FAST_READ, OP_DUAL_OUT, OP_QUAD_OUT,
    OP_DUAL_IO, OP_QUAD_IO, OP_WORD_QUAD_IO};
  int n_fail = 0;
  int comparisons = 0;
  flash_link_if flash_link_if_i ();
  always #50 clock = ~clock;
  flash_read_host flash_read_host_i (.clock(clock), .rst_b(rst_b),
    .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'b010), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
    .link(flash_link_if_i.host));
  flash_read_device flash_read_device_i (.clock(clock), .rst_b(rst_b),
    .link(flash_link_if_i.dev), .quad_lines_enable_bit(qe),
    .load_en(ld), .load_addr(ld_a), .load_data(ld_d),
    .continuous_read_mode_byte(mode_b), .opcode_skip_active(skip),
    .wrap_setting_bits(wrap), .frame_active(fa));
  flash_read_props flash_read_props_i (.clock(clock), .rst_b(rst_b),
    .sclk(flash_link_if_i.sclk), .cs_b(flash_link_if_i.cs_b),
    .host_io_out(flash_link_if_i.host_io_out),
    .host_io_oe(flash_link_if_i.host_io_oe),
    .dev_io_out(flash_link_if_i.dev_io_out),
    .dev_io_oe(flash_link_if_i.dev_io_oe));
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  task chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clock); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clock); while (hready !== 1'b1);
    r = hrdata;
  endtask : bus
  task poll(input logic [7:0] a, input int b, input logic v);
    int k;
    k = 0;
    do begin
      bus(1'b0, a, 32'h0);
      k++;
    end while (r[b] !== v && k < 500);
    // A poll that runs out counts against the run
    if (r[b] !== v) n_fail++;
  endtask : poll
  // Expected byte: refused reads float high; wrap only for quad I/O and word quad reads
  function automatic logic [7:0] ex(logic [7:0] op, logic [23:0] a,
                                    int i);
    logic [23:0] p;
    logic [23:0] m;
    if (!qe && (op == OP_QUAD_OUT || op == OP_QUAD_IO ||
                op == OP_WORD_QUAD_IO))
      return 8'hff;
    if (op == OP_WORD_QUAD_IO)
      a[0] = 1'b0;
    p = a + 24'(i);
    m = 24'h8 << wrap_e[2:1];
    if ((op == OP_QUAD_IO || op == OP_WORD_QUAD_IO) && !wrap_e[0])
      p = (a & ~(m - 24'h1)) | (p & (m - 24'h1));
    return mem[p[9:0]];
  endfunction : ex
  task go(input logic [9:0] c, input logic [23:0] a, input logic [7:0] m,
          input int n);
    bus(1'b1, REG_ADDR, {8'h0, a});
    bus(1'b1, REG_MODE, {24'h0, m});
    bus(1'b1, REG_COUNT, n);
    bus(1'b1, REG_CMD, {22'h0, c});
    for (int i = 0; i < n; i++) begin
      poll(REG_DATA, 8, 1'b1);
      chk(r[7:0], ex(c[7:0], a, i));
    end
    poll(REG_STATUS, 1, 1'b0);
    repeat (4) @(posedge clock);
    chk({7'h0, fa}, 8'h00);
    $display("test %h done", c);
  endtask : go
  initial begin
    #9_000_000;
    n_fail++;
    report_and_stop;
  end
  initial begin
    void'($urandom(32'ha224));
    foreach (mem[i]) mem[i] = 8'($urandom);
    wrap_e = WRAP_SETTING_RESET;
    repeat (4) @(posedge clock);
    chk(mode_b, MODE_BYTE_RESET);
    chk({5'h0, wrap}, {5'h0, WRAP_SETTING_RESET});
    rst_b <= 1'b1;
    // Memory has no reset, so it is loaded over the back door
    foreach (mem[i]) begin
      @(posedge clock);
      ld <= 1'b1;
      ld_a <= 10'(i);
      ld_d <= mem[i];
    end
    @(posedge clock);
    ld <= 1'b0;
    bus(1'b0, 8'h20, 32'h0);
    chk(r[7:0], 8'h00);
    foreach (ops[i]) go({2'b0, ops[i]}, 24'($urandom), 8'h00, i + 3);
    qe <= 1'b0;
    foreach (ops[i]) if (i == 2 || i > 3) go({2'b0, ops[i]}, 24'h10, 8'h0, 2);
    qe <= 1'b1;
    go({2'b0, OP_QUAD_IO}, 24'($urandom), 8'h25, 2);
    chk(mode_b, 8'h25);
    chk({7'h0, skip}, 8'h01);
    go({2'b01, OP_QUAD_IO}, 24'($urandom), 8'h2f, 3);
    chk({7'h0, skip}, 8'h01);
    go({2'b00, OP_MODE_RESET}, 24'h0, 8'h00, 0);
    chk({7'h0, skip}, 8'h00);
    go({2'b00, OP_DUAL_IO}, 24'($urandom), 8'h20, 2);
    go({2'b10, OP_MODE_RESET}, 24'h0, 8'h00, 0);
    chk({7'h0, skip}, 8'h00);
    go({2'b00, OP_DUAL_IO}, 24'($urandom), 8'h20, 1);
    go({2'b01, OP_DUAL_IO}, 24'($urandom), 8'h30, 2);
    chk({7'h0, skip}, 8'h00);
    go({2'b00, OP_FAST_READ}, 24'($urandom), 8'h00, 2);
    for (int w = 0; w < 4; w++) begin
      go({2'b0, OP_SET_WRAP}, 24'h0, {1'b0, 2'(w), 5'h0}, 0);
      wrap_e = {2'(w), 1'b0};
      chk({5'h0, wrap}, {5'h0, wrap_e});
      go({2'b0, OP_QUAD_IO}, 24'($urandom), 8'h00, (8 << w) + 3);
    end
    go({2'b0, OP_WORD_QUAD_IO}, 24'h000123, 8'h00, 10);
    go({2'b0, OP_SET_WRAP}, 24'h0, 8'h10, 0);
    wrap_e = 3'b001;
    go({2'b0, OP_QUAD_IO}, 24'h0000fd, 8'h00, 10);
    report_and_stop;
  end
endmodule : serial_flash_multi_io_read_tb
